// file: shared/ttg_consts.vh
// Constants for the transmitter timeout guard and self-test block
// Operation
// - Monitor activity hidden when indicate bit clear, unless other_in_mt_msg is set
// - Indicate bit set ORs monitor activity in while monitor enabled
// - Low config bit always reads zero
// - Per-bus watchdog cuts transmission past 663us
// - Arm: pin, write one, then write zero
// - Pin may drop after the one write
// - Armed reply sends 35 incrementing words
// - Watchdog stops test burst at 663us
// - Cutoff sets loopback-fail pending bit if enabled
// - Trigger bit self-clears, always reads zero
// - Pending flag set when arming completes
// - Pending flag clears when test transmission starts
// - Host performs bus shutdown via inhibit bits
`ifndef TTG_CONSTS_VH
`define TTG_CONSTS_VH
`define TTG_ADDR_CFG2 16'h004e
`define TTG_ADDR_CFG_LOW 16'h0000
`define TTG_ADDR_RT_CFG 16'h0017
`define TTG_ADDR_HW_PEND 16'h0006
`define TTG_BIT_TRIGGER 15
`define TTG_BIT_PENDING 14
`define TTG_BIT_MON_IND 1
`define TTG_BIT_AUTO_BSD 0
`define TTG_BIT_INH_A 1
`define TTG_BIT_INH_B 2
`define TTG_BIT_LBF_A 12
`define TTG_BIT_LBF_B 11
`define TTG_TIMEOUT_NS 663000
`define TTG_CLK_NS 5
`define TTG_TEST_WORDS 6'h23
`define TTG_ZERO16 16'h0000
`endif

// file: hdl/ttg_guard.v
// Transmitter timeout watchdogs, timeout self-test arming and activity merge
`timescale 1ns/1ps
`include "ttg_consts.vh"
module ttg_guard #(
  parameter TIMEOUT_CYCLES = `TTG_TIMEOUT_NS / `TTG_CLK_NS
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire test_pin,
  input wire host_wr,
  input wire host_rd,
  input wire [15:0] host_addr,
  input wire [15:0] host_wdata,
  output reg [15:0] host_rdata,
  input wire tx_a_req,
  input wire tx_b_req,
  input wire [15:0] tx_a_data,
  input wire [15:0] tx_b_data,
  output wire tx_a_en,
  output wire tx_b_en,
  output reg [15:0] tx_a_out,
  output reg [15:0] tx_b_out,
  input wire rt_tx_start,
  input wire rt_tx_bus_b,
  output wire test_burst_active,
  output reg [5:0] test_word_count,
  input wire word_done,
  input wire lbf_irq_en_a,
  input wire lbf_irq_en_b,
  output reg lbf_pend_a,
  output reg lbf_pend_b,
  input wire [15:0] hw_pend_clear,
  input wire mt_active,
  input wire mt_enabled,
  input wire other_active,
  input wire other_in_mt_msg,
  output wire active_out,
  input wire mc_shutdown_rx,
  output wire auto_bus_shutdown_disable,
  output wire bus_a_inhibit,
  output wire bus_b_inhibit
);

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  reg monitor_activity_indicate_reg;
  reg auto_bsd_reg;
  reg inh_a_reg;
  reg inh_b_reg;
  reg tx_timeout_test_pending_reg;
  reg trig_seen_reg;        // One written to trigger with test_pin high on the previous access
  reg test_run_reg;
  reg test_bus_b_reg;
  reg [31:0] wd_a_reg;
  reg [31:0] wd_b_reg;
  reg trip_a_reg;
  reg trip_b_reg;

  wire access = host_wr | host_rd;
  wire wr_cfg2 = host_wr && (host_addr == `TTG_ADDR_CFG2);
  wire wr_low = host_wr && (host_addr == `TTG_ADDR_CFG_LOW);
  wire wr_rt = host_wr && (host_addr == `TTG_ADDR_RT_CFG);
  wire arm_done = trig_seen_reg && wr_cfg2 && !host_wdata[`TTG_BIT_TRIGGER];
  wire start_test = tx_timeout_test_pending_reg && rt_tx_start;

  // ------------------------------------------------------------
  // Host configuration writes
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      monitor_activity_indicate_reg <= 1'b0;
      auto_bsd_reg <= 1'b0;
      inh_a_reg <= 1'b0;
      inh_b_reg <= 1'b0;
    end else begin
      if (wr_low) begin
        monitor_activity_indicate_reg <= host_wdata[`TTG_BIT_MON_IND];
      end
      if (wr_rt) begin
        auto_bsd_reg <= host_wdata[`TTG_BIT_AUTO_BSD];
        inh_a_reg <= host_wdata[`TTG_BIT_INH_A];
        inh_b_reg <= host_wdata[`TTG_BIT_INH_B];
      end
    end
  end

  // Shutdown commands only ever come from host inhibit writes here; the received
  // command is deliberately ignored when the host owns shutdown
  assign auto_bus_shutdown_disable = auto_bsd_reg;
  assign bus_a_inhibit = inh_a_reg;
  assign bus_b_inhibit = inh_b_reg;

  // ------------------------------------------------------------
  // Self-test arming sequence
  // ------------------------------------------------------------
  // Any access after the one write either completes or aborts the sequence
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      trig_seen_reg <= 1'b0;
      tx_timeout_test_pending_reg <= 1'b0;
    end else begin
      if (access) begin
        trig_seen_reg <= wr_cfg2 && host_wdata[`TTG_BIT_TRIGGER] && test_pin;
      end
      if (arm_done) begin
        tx_timeout_test_pending_reg <= 1'b1;
      end else if (start_test) begin
        tx_timeout_test_pending_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Test burst: 35 words of incrementing count
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      test_run_reg <= 1'b0;
      test_bus_b_reg <= 1'b0;
      test_word_count <= 6'h00;
    end else if (start_test) begin
      test_run_reg <= 1'b1;
      test_bus_b_reg <= rt_tx_bus_b;
      test_word_count <= 6'h00;
    end else if (test_run_reg) begin
      if ((test_bus_b_reg ? trip_b_reg : trip_a_reg) ||
          (word_done && test_word_count == `TTG_TEST_WORDS - 6'h01)) begin
        test_run_reg <= 1'b0;
      end else if (word_done) begin
        test_word_count <= test_word_count + 6'h01;
      end
    end
  end
  assign test_burst_active = test_run_reg;

  // ------------------------------------------------------------
  // Per-bus watchdogs
  // ------------------------------------------------------------
  wire req_a = tx_a_req | (test_run_reg & ~test_bus_b_reg);
  wire req_b = tx_b_req | (test_run_reg & test_bus_b_reg);
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      wd_a_reg <= 32'h00000000;
      wd_b_reg <= 32'h00000000;
      trip_a_reg <= 1'b0;
      trip_b_reg <= 1'b0;
    end else begin
      // Idle clears both count and trip so the next transmission starts fresh
      if (!req_a) begin
        wd_a_reg <= 32'h00000000;
        trip_a_reg <= 1'b0;
      end else if (wd_a_reg >= TIMEOUT_CYCLES - 1) begin
        trip_a_reg <= 1'b1;
      end else begin
        wd_a_reg <= wd_a_reg + 32'h00000001;
      end
      if (!req_b) begin
        wd_b_reg <= 32'h00000000;
        trip_b_reg <= 1'b0;
      end else if (wd_b_reg >= TIMEOUT_CYCLES - 1) begin
        trip_b_reg <= 1'b1;
      end else begin
        wd_b_reg <= wd_b_reg + 32'h00000001;
      end
    end
  end
  assign tx_a_en = req_a & ~trip_a_reg & ~inh_a_reg;
  assign tx_b_en = req_b & ~trip_b_reg & ~inh_b_reg;

  // Transmit data: test words carry the running count
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      tx_a_out <= `TTG_ZERO16;
      tx_b_out <= `TTG_ZERO16;
    end else begin
      tx_a_out <= (test_run_reg & ~test_bus_b_reg) ? {10'h000, test_word_count} : tx_a_data;
      tx_b_out <= (test_run_reg & test_bus_b_reg) ? {10'h000, test_word_count} : tx_b_data;
    end
  end

  // ------------------------------------------------------------
  // Loopback-fail pending bits; a new cutoff beats a same-cycle clear
  // ------------------------------------------------------------
  wire cut_a = test_run_reg & ~test_bus_b_reg & trip_a_reg;
  wire cut_b = test_run_reg & test_bus_b_reg & trip_b_reg;
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      lbf_pend_a <= 1'b0;
      lbf_pend_b <= 1'b0;
    end else begin
      if (cut_a && lbf_irq_en_a) begin
        lbf_pend_a <= 1'b1;
      end else if (hw_pend_clear[`TTG_BIT_LBF_A]) begin
        lbf_pend_a <= 1'b0;
      end
      if (cut_b && lbf_irq_en_b) begin
        lbf_pend_b <= 1'b1;
      end else if (hw_pend_clear[`TTG_BIT_LBF_B]) begin
        lbf_pend_b <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Activity output
  // ------------------------------------------------------------
  assign active_out = other_active |
                      (monitor_activity_indicate_reg & mt_enabled & mt_active) |
                      (mt_active & other_in_mt_msg);

  // ------------------------------------------------------------
  // Register read data
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      host_rdata <= `TTG_ZERO16;
    end else if (host_rd) begin
      host_rdata <= `TTG_ZERO16;
      case (host_addr)
        `TTG_ADDR_CFG2: host_rdata[`TTG_BIT_PENDING] <= tx_timeout_test_pending_reg;
        `TTG_ADDR_CFG_LOW: host_rdata[`TTG_BIT_MON_IND] <= monitor_activity_indicate_reg;
        `TTG_ADDR_RT_CFG: begin
          host_rdata[`TTG_BIT_AUTO_BSD] <= auto_bsd_reg;
          host_rdata[`TTG_BIT_INH_A] <= inh_a_reg;
          host_rdata[`TTG_BIT_INH_B] <= inh_b_reg;
        end
        `TTG_ADDR_HW_PEND: begin
          host_rdata[`TTG_BIT_LBF_A] <= lbf_pend_a;
          host_rdata[`TTG_BIT_LBF_B] <= lbf_pend_b;
        end
        default: host_rdata <= `TTG_ZERO16;
      endcase
    end
  end

endmodule // ttg_guard

// file: verification/ttg_guard_properties.sv
// Timing checks on the timeout guard ports
`timescale 1ns/1ps
module ttg_props #(parameter TIMEOUT_CYCLES = 50) (
  input wire clk_sys,
  input wire sys_rst,
  input wire host_wr,
  input wire host_rd,
  input wire [15:0] host_addr,
  input wire [15:0] host_wdata,
  input wire [15:0] host_rdata,
  input wire tx_a_req,
  input wire tx_a_en,
  input wire bus_a_inhibit,
  input wire rt_tx_start,
  input wire test_burst_active,
  input wire lbf_irq_en_a,
  input wire lbf_pend_a,
  input wire mt_active,
  input wire mt_enabled,
  input wire other_active,
  input wire other_in_mt_msg,
  input wire active_out,
  input wire mc_shutdown_rx
);
  reg ind_shadow_reg;
  int cnt_reg;
  // Shadow of the indicate bit and run length of channel A requests
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      ind_shadow_reg <= 1'h0;
      cnt_reg <= 0;
    end else begin
      if (host_wr && host_addr == 16'h0000) ind_shadow_reg <= host_wdata[1];
      cnt_reg <= tx_a_req ? cnt_reg + 1 : 0;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  low_bit_zero_a: assert property (host_rd && host_addr == 16'h0000 |=> !host_rdata[0])
    else $error("low config bit read as one");
  trig_reads_zero_a: assert property (host_rd && host_addr == 16'h004e |=> !host_rdata[15])
    else $error("trigger bit read as one");
  mt_hidden_a: assert property (!ind_shadow_reg && !other_active && !other_in_mt_msg |-> !active_out)
    else $error("monitor activity shown while hidden");
  mt_shown_a: assert property (ind_shadow_reg && mt_active && mt_enabled |-> active_out)
    else $error("monitor activity not shown");
  tx_cutoff_a: assert property (cnt_reg > TIMEOUT_CYCLES + 1 |-> !tx_a_en)
    else $error("transmitter ran past limit");
  tx_restart_a: assert property ($rose(tx_a_req) && !bus_a_inhibit |-> tx_a_en)
    else $error("new transmission not enabled");
  burst_cause_a: assert property ($rose(test_burst_active) |-> rt_tx_start || $past(rt_tx_start))
    else $error("test burst began without start");
  pend_enable_a: assert property ($rose(lbf_pend_a) |-> lbf_irq_en_a || $past(lbf_irq_en_a))
    else $error("pending bit set while disabled");
  host_owns_a: assert property (mc_shutdown_rx && !host_wr |=> $stable(bus_a_inhibit))
    else $error("inhibit moved by shutdown command");
  cover property ($rose(test_burst_active));
  cover property ($rose(lbf_pend_a));
  cover property (ind_shadow_reg && mt_active && mt_enabled && !other_active);
endmodule // ttg_props
bind ttg_guard ttg_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_props (.*);

// file: verification/ttg_xcvr.sv
// Transceiver stand-in pulsing once per word sent
`timescale 1ns/1ps
module ttg_xcvr #(parameter WORD_CYCLES = 2) (
  input wire clk_sys,
  input wire tx_a_en,
  input wire tx_b_en,
  output reg word_done
);
  int cyc_reg = 0;
  // Word clock runs only while a transmitter drives, so idle sends nothing
  always @(posedge clk_sys) begin
    cyc_reg <= (tx_a_en || tx_b_en) && cyc_reg < WORD_CYCLES - 1 ? cyc_reg + 1 : 0;
    word_done <= (tx_a_en || tx_b_en) && cyc_reg == WORD_CYCLES - 1;
  end
endmodule // ttg_xcvr

// file: verification/testbench.sv
// Self-checking bench for the transmitter timeout guard
`timescale 1ns/1ps
module testbench;
  localparam int TC = 50;
  logic clk_sys = 1'h0, sys_rst = 1'h1, test_pin = 1'h0, host_wr = 1'h0, host_rd = 1'h0;
  logic tx_a_req = 1'h0, tx_b_req = 1'h0, rt_tx_start = 1'h0, rt_tx_bus_b = 1'h0;
  logic lbf_irq_en_a = 1'h0, lbf_irq_en_b = 1'h0, mt_active = 1'h0, mt_enabled = 1'h0;
  logic other_active = 1'h0, other_in_mt_msg = 1'h0, mc_shutdown_rx = 1'h0;
  logic word_done, tx_a_en, tx_b_en, test_burst_active, lbf_pend_a, lbf_pend_b, active_out;
  logic auto_bus_shutdown_disable, bus_a_inhibit, bus_b_inhibit;
  logic [15:0] host_addr = 16'h0000, host_wdata = 16'h0000, hw_pend_clear = 16'h0000;
  logic [15:0] tx_a_data = 16'h1234, tx_b_data = 16'h5678, host_rdata, tx_a_out, tx_b_out;
  logic [5:0] test_word_count;
  int miscompares = 0, cmp_count = 0;
  // Rows: indicate, monitor active, monitor enabled, other active, other in msg, expected
  logic [5:0] rows [6] = '{6'h18, 6'h39, 6'h30, 6'h05, 6'h28, 6'h1f};
  ttg_guard #(.TIMEOUT_CYCLES(TC)) dut (.*);
  ttg_xcvr u_xcvr (.*);
  always #2.5 clk_sys = ~clk_sys;
  task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", nm, e, s);
    end
  endtask
  // One host access; strobe held for exactly the taking edge
  task acc(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    host_wr <= w;
    host_rd <= !w;
    host_addr <= a;
    host_wdata <= d;
    @(posedge clk_sys);
    host_wr <= 1'h0;
    host_rd <= 1'h0;
  endtask
  task rd(input logic [15:0] a, input logic [15:0] e, input string nm);
    acc(1'h0, a, 16'h0000);
    @(negedge clk_sys);
    chk(nm, e, host_rdata);
  endtask
  task close_out;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Hang guard, well beyond the few hundred cycles the tests need
  initial begin
    repeat (4000) @(posedge clk_sys);
    miscompares++;
    close_out;
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'h0;
    rd(16'h004e, 16'h0000, "cfg2 reset");
    rd(16'h0123, 16'h0000, "unmapped");
    // Activity merge table; bit 0 is written as one but must read zero
    foreach (rows[i]) begin
      acc(1'h1, 16'h0000, {14'h0000, rows[i][5], 1'h1});
      {mt_active, mt_enabled, other_active, other_in_mt_msg} <= rows[i][4:1];
      @(negedge clk_sys);
      chk("active", {15'h0000, rows[i][0]}, {15'h0000, active_out});
      rd(16'h0000, {14'h0000, rows[i][5], 1'h0}, "cfg low");
    end
    // Both channels overrun the limit, then channel A starts afresh
    @(posedge clk_sys);
    {tx_a_req, tx_b_req} <= 2'h3;
    repeat (TC + 3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("tx cut", 16'h0000, {14'h0000, tx_a_en, tx_b_en});
    @(posedge clk_sys);
    {tx_a_req, tx_b_req} <= 2'h0;
    @(posedge clk_sys);
    tx_a_req <= 1'h1;
    @(negedge clk_sys);
    chk("tx restart", 16'h0001, {15'h0000, tx_a_en});
    // Host owns shutdown: the received command must not move the inhibits
    acc(1'h1, 16'h0017, 16'h0003);
    mc_shutdown_rx <= 1'h1;
    repeat (2) begin
      @(negedge clk_sys);
      chk("inhibit", 16'h000c, {auto_bus_shutdown_disable, bus_a_inhibit, bus_b_inhibit,
        tx_a_en});
    end
    @(posedge clk_sys);
    mc_shutdown_rx <= 1'h0;
    tx_a_req <= 1'h0;
    acc(1'h1, 16'h0017, 16'h0000);
    lbf_irq_en_a <= 1'h1;
    // First pass breaks the sequence with a read, second completes it
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      test_pin <= 1'h1;
      acc(1'h1, 16'h004e, 16'h8000);
      test_pin <= 1'h0;
      if (k == 0) rd(16'h0000, 16'h0000, "between");
      acc(1'h1, 16'h004e, 16'h0000);
      rd(16'h004e, k ? 16'h4000 : 16'h0000, "pending");
    end
    @(posedge clk_sys);
    rt_tx_start <= 1'h1;
    tx_a_req <= 1'h1;
    @(posedge clk_sys);
    rt_tx_start <= 1'h0;
    @(negedge clk_sys);
    chk("burst", 16'h0001, {15'h0000, test_burst_active});
    rd(16'h004e, 16'h0000, "pending clr");
    repeat (TC) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("burst cut", 16'h0001, {14'h0000, tx_a_en, lbf_pend_a});
    chk("words", 16'h0001, {15'h0000, test_word_count > 6'h00 && test_word_count < 6'h23});
    rd(16'h0006, 16'h1000, "hw pend");
    // Clear channel A pending, then a bus B test whose interrupt stays disabled
    @(posedge clk_sys);
    hw_pend_clear <= 16'h1000;
    tx_a_req <= 1'h0;
    @(posedge clk_sys);
    hw_pend_clear <= 16'h0000;
    @(negedge clk_sys);
    chk("pend clr", 16'h0000, {14'h0000, lbf_pend_a, lbf_pend_b});
    @(posedge clk_sys);
    test_pin <= 1'h1;
    acc(1'h1, 16'h004e, 16'h8000);
    test_pin <= 1'h0;
    acc(1'h1, 16'h004e, 16'h0000);
    @(posedge clk_sys);
    rt_tx_start <= 1'h1;
    rt_tx_bus_b <= 1'h1;
    @(posedge clk_sys);
    rt_tx_start <= 1'h0;
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("b run", 16'h0003, {14'h0000, tx_b_en, tx_b_out < 16'h0023});
    repeat (TC - 8) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("b cut", 16'h0000, {13'h0000, tx_b_en, test_burst_active, lbf_pend_b});
    chk("b words", 16'h0001, {15'h0000, test_word_count > 6'h00 && test_word_count < 6'h23});
    chk("a data", 16'h1234, tx_a_out);
    chk("b data", 16'h5678, tx_b_out);
    close_out;
  end
endmodule // testbench
